// File: tmrg_pkg.sv
// tmrg_pkg: constants for the 16-bit timer with overflow flag and gate control.
// assumes a single system clock; external count clock arrives as a synchronous level.
package tmrg_pkg;
  localparam int          COUNT_W      = 16;
  localparam logic [15:0] COUNT_MAX    = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic        FLAG_RESET   = 1'h0;
  localparam logic        SEL_SYSTEM   = 1'h0;
  localparam logic        SEL_EXTERNAL = 1'h1;
  typedef enum logic [1:0] {TMRG_IDLE, TMRG_WAIT_RISE, TMRG_COUNTING} tmrg_gate_state_t;
endpackage : tmrg_pkg

// File: tmrg_edge.sv
// tmrg_edge: rise and fall detection of a synchronous level.
// assumes the input is already synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module tmrg_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in, edges out
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev <= 1'h0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // tmrg_edge
`default_nettype wire

// File: tmrg_timer.sv
// tmrg_timer: 16-bit counter pair with overflow flag, sleep wake and gate single-pulse.
// assumes control bits are held by software registers outside; all inputs synchronous to CLK_SYS.
`timescale 1ns/100ps
`default_nettype none
// Operation
// (RQ1) counter pair increments to all-ones, then wraps to zero.
// (RQ2) wrap sets the overflow flag.
// (RQ3) software enables run, overflow, peripheral and global enables for an interrupt.
// (RQ4) overflow flag stays until software writes zero.
// (RQ5) software clears counter and flag before enabling interrupts.
// (RQ6) in sleep only the asynchronous counter configuration keeps counting.
// (RQ7) asynchronous mode counts external clock edges, not system clock.
// (RQ8) software sets run, enables, sync disable and clock select to wake.
// (RQ9) overflow in sleep wakes the device to the next instruction.
// (RQ10) after waking, branch to service routine only with global enable set.
// (RQ11) the timer oscillator keeps running in sleep regardless of sync disable.
// (RQ12) software arms go/done; hardware clears it on gate value falling.
// (RQ13) gate value falling sets gate event flag; software clears it.
// (RQ14) single-pulse counts only while armed gate active; holds once done.
module tmrg_timer (
  // clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // control bits
  input  wire logic        TIMER_RUN,
  input  wire logic        COUNT_CLOCK_SELECT,
  input  wire logic        SYNC_DISABLE,
  input  wire logic        OSC_ENABLE,
  input  wire logic        OVERFLOW_IRQ_ENABLE,
  input  wire logic        PERIPHERAL_IRQ_ENABLE,
  input  wire logic        GLOBAL_IRQ_ENABLE,
  input  wire logic        SLEEP_ACTIVE,
  // gate control
  input  wire logic        GATE_ENABLE,
  input  wire logic        GATE_POLARITY,
  input  wire logic        GATE_TOGGLE_MODE,
  input  wire logic        GATE_SINGLE_PULSE_MODE,
  input  wire logic        GATE_ARM_SET,
  input  wire logic        GATE_IN,
  // external clock
  input  wire logic        EXT_CLOCK_IN,
  // software writes
  input  wire logic        COUNT_WRITE,
  input  wire logic [15:0] COUNT_WRITE_DATA,
  input  wire logic        OVERFLOW_FLAG_CLEAR,
  input  wire logic        GATE_EVENT_FLAG_CLEAR,
  // status
  output logic [7:0]       COUNT_HIGH_BYTE,
  output logic [7:0]       COUNT_LOW_BYTE,
  output logic             OVERFLOW_FLAG,
  output logic             GATE_EVENT_FLAG,
  output logic             GATE_ARM_PENDING,
  output logic             GATE_VALUE,
  output logic             OSC_RUNNING,
  // wake and interrupt
  output logic             WAKE_REQUEST,
  output logic             IRQ_BRANCH
);
  logic [15:0] count;
  logic        ext_rise;
  logic        gv_rise;
  logic        gv_fall;
  logic        gate_raw;
  logic        toggle_q;
  logic        tick;
  logic        gate_open;
  logic        inc;
  logic        wrap;
  tmrg_pkg::tmrg_gate_state_t sp_state;

  tmrg_edge u_ext_edge (
    .clk   (CLK_SYS),
    .rst   (RST),
    .level (EXT_CLOCK_IN),
    .rise  (ext_rise),
    .fall  ()
  );

  tmrg_edge u_gate_edge (
    .clk   (CLK_SYS),
    .rst   (RST),
    .level (GATE_VALUE),
    .rise  (gv_rise),
    .fall  (gv_fall)
  );

  // raw gate level after polarity; toggle mode flips toggle_q on every tick while it is active
  assign gate_raw = GATE_IN ^ ~GATE_POLARITY;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      toggle_q <= 1'h0;
    end else if (!GATE_TOGGLE_MODE || !GATE_ENABLE) begin
      toggle_q <= 1'h0;
    end else if (gate_raw && tick) begin
      toggle_q <= ~toggle_q;
    end
  end

  // single-pulse: armed waits for rising gate value, counts until it falls
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sp_state <= tmrg_pkg::TMRG_IDLE;
    end else begin
      unique case (sp_state)
        tmrg_pkg::TMRG_IDLE: begin
          if (GATE_ARM_SET && GATE_SINGLE_PULSE_MODE && GATE_ENABLE) begin
            sp_state <= tmrg_pkg::TMRG_WAIT_RISE;
          end
        end
        tmrg_pkg::TMRG_WAIT_RISE: begin
          if (!GATE_SINGLE_PULSE_MODE || !GATE_ENABLE) begin
            sp_state <= tmrg_pkg::TMRG_IDLE;
          end else if (gv_rise) begin
            sp_state <= tmrg_pkg::TMRG_COUNTING;
          end
        end
        tmrg_pkg::TMRG_COUNTING: begin
          if (gv_fall || !GATE_SINGLE_PULSE_MODE || !GATE_ENABLE) begin
            sp_state <= tmrg_pkg::TMRG_IDLE; // RQ12
          end
        end
        default: sp_state <= tmrg_pkg::TMRG_IDLE;
      endcase
    end
  end

  // gate value is registered so it changes only on the clock
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      GATE_VALUE <= 1'h0;
    end else if (!GATE_ENABLE) begin
      GATE_VALUE <= 1'h0;
    end else if (GATE_TOGGLE_MODE) begin
      GATE_VALUE <= toggle_q;
    end else begin
      GATE_VALUE <= gate_raw;
    end
  end

  assign GATE_ARM_PENDING = (sp_state != tmrg_pkg::TMRG_IDLE);

  // sleep stops the system clock path; only external async counting survives
  assign tick = (COUNT_CLOCK_SELECT == tmrg_pkg::SEL_EXTERNAL) ? ext_rise : ~SLEEP_ACTIVE; // RQ7
  assign gate_open = !GATE_ENABLE ? 1'h1 :
                     GATE_SINGLE_PULSE_MODE ? (sp_state == tmrg_pkg::TMRG_COUNTING) && GATE_VALUE : // RQ14
                     GATE_VALUE;
  assign inc = TIMER_RUN && tick && gate_open &&
               (!SLEEP_ACTIVE || (COUNT_CLOCK_SELECT == tmrg_pkg::SEL_EXTERNAL && SYNC_DISABLE)); // RQ6
  assign wrap = inc && (count == tmrg_pkg::COUNT_MAX);

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      count <= tmrg_pkg::COUNT_RESET;
    end else if (COUNT_WRITE) begin
      count <= COUNT_WRITE_DATA;
    end else if (inc) begin
      count <= count + 16'h0001; // RQ1
    end
  end

  assign COUNT_HIGH_BYTE = count[15:8];
  assign COUNT_LOW_BYTE  = count[7:0];

  // set wins over a clear in the same cycle so no wrap is lost
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      OVERFLOW_FLAG <= tmrg_pkg::FLAG_RESET;
    end else if (wrap) begin
      OVERFLOW_FLAG <= 1'h1; // RQ2
    end else if (OVERFLOW_FLAG_CLEAR) begin
      OVERFLOW_FLAG <= 1'h0; // RQ4
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      GATE_EVENT_FLAG <= tmrg_pkg::FLAG_RESET;
    end else if (GATE_ENABLE && gv_fall) begin
      GATE_EVENT_FLAG <= 1'h1; // RQ13
    end else if (GATE_EVENT_FLAG_CLEAR) begin
      GATE_EVENT_FLAG <= 1'h0;
    end
  end

  // oscillator ignores sleep and sync disable on purpose
  assign OSC_RUNNING = OSC_ENABLE; // RQ11

  assign WAKE_REQUEST = SLEEP_ACTIVE && OVERFLOW_FLAG && OVERFLOW_IRQ_ENABLE && PERIPHERAL_IRQ_ENABLE; // RQ9
  assign IRQ_BRANCH = OVERFLOW_FLAG && OVERFLOW_IRQ_ENABLE && PERIPHERAL_IRQ_ENABLE && GLOBAL_IRQ_ENABLE; // RQ10

  a_count_wraps: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ1
    (inc && !COUNT_WRITE && count == tmrg_pkg::COUNT_MAX) |=> (count == tmrg_pkg::COUNT_ZERO))
    else $error("counter did not wrap to zero");
  a_count_steps: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ1
    (inc && !COUNT_WRITE) |=> (count == $past(count) + 16'h0001))
    else $error("counter did not step by one");
  a_wrap_sets_flag: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ2
    wrap |=> OVERFLOW_FLAG)
    else $error("wrap did not set overflow flag");
  a_flag_holds: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ4
    (OVERFLOW_FLAG && !OVERFLOW_FLAG_CLEAR) |=> OVERFLOW_FLAG)
    else $error("overflow flag cleared without software");
  a_sleep_stops: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ6
    (SLEEP_ACTIVE && !(COUNT_CLOCK_SELECT && SYNC_DISABLE) && !COUNT_WRITE) |=> $stable(count))
    else $error("counter moved in sleep outside async mode");
  a_ext_only: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ7
    (COUNT_CLOCK_SELECT && !ext_rise && !COUNT_WRITE) |=> $stable(count))
    else $error("async counter moved without external edge");
  a_wake_on_flag: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ9
    (SLEEP_ACTIVE && OVERFLOW_IRQ_ENABLE && PERIPHERAL_IRQ_ENABLE && wrap) |=> WAKE_REQUEST)
    else $error("overflow in sleep did not wake");
  a_branch_gie: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ10
    IRQ_BRANCH |-> GLOBAL_IRQ_ENABLE)
    else $error("branch without global enable");
  a_osc_runs: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ11
    (SLEEP_ACTIVE && OSC_ENABLE) |-> OSC_RUNNING)
    else $error("oscillator stopped in sleep");
  a_arm_done: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ12
    (sp_state == tmrg_pkg::TMRG_COUNTING && gv_fall) |=> !GATE_ARM_PENDING)
    else $error("go/done not cleared on gate fall");
  a_gate_event: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ13
    (GATE_ENABLE && gv_fall) |=> GATE_EVENT_FLAG)
    else $error("gate fall did not set event flag");
  a_pulse_hold: assert property (@(posedge CLK_SYS) disable iff (RST) // RQ14
    (GATE_ENABLE && GATE_SINGLE_PULSE_MODE && !GATE_ARM_PENDING && !COUNT_WRITE) |=> $stable(count))
    else $error("single-pulse counted after done");
endmodule // tmrg_timer
`default_nettype wire

// File: tmrg_ext_src.sv
// tmrg_ext_src: external count clock and gate pin source for the timer bench.
// assumes run and gate level come from the bench off the system clock edge.
`timescale 1ns/100ps
`default_nettype none
module tmrg_ext_src (
  // bench control
  input  wire logic clk,
  input  wire logic run,
  input  wire logic gate_level,
  // pins toward the timer
  output logic      ext_clk,
  output logic      gate_pin
);
  logic [1:0] div;
  // idles low outside runs; eight system cycles a period so every rise is seen
  always_ff @(negedge clk) begin
    if (!run) begin
      div <= 2'h0;
      ext_clk <= 1'h0;
    end else begin
      div <= div + 2'h1;
      if (div == 2'h3) ext_clk <= ~ext_clk;
    end
  end
  assign gate_pin = gate_level;
endmodule // tmrg_ext_src
`default_nettype wire

// File: tb.sv
// tb: directed tests of the timer: wrap, sleep counting and wake, gate single pulse.
// assumes tmrg_timer and tmrg_ext_src; inputs change on the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tb;
  logic clk, rst, run, sel, sdis, osc, oie, pie, global_irq_enable, slp, gen, gpol, gtm, gspm;
  logic garm, ext_run, gate_lvl, ext_clk, gate_pin, cwr, ofc, gfc;
  logic of, gf, gpend, gval, oscr, wake, brn;
  logic [7:0]  hi, lo;
  logic [15:0] cwd, c0, cnt;
  int          n_fail = 0;
  int          tests_run = 0;
  assign cnt = {hi, lo};
  tmrg_ext_src u_src (.clk(clk), .run(ext_run), .gate_level(gate_lvl), .ext_clk(ext_clk), .gate_pin(gate_pin));
  tmrg_timer u_dut (.CLK_SYS(clk), .RST(rst), .TIMER_RUN(run), .COUNT_CLOCK_SELECT(sel),
    .SYNC_DISABLE(sdis), .OSC_ENABLE(osc), .OVERFLOW_IRQ_ENABLE(oie), .PERIPHERAL_IRQ_ENABLE(pie),
    .GLOBAL_IRQ_ENABLE(global_irq_enable), .SLEEP_ACTIVE(slp), .GATE_ENABLE(gen), .GATE_POLARITY(gpol),
    .GATE_TOGGLE_MODE(gtm), .GATE_SINGLE_PULSE_MODE(gspm), .GATE_ARM_SET(garm), .GATE_IN(gate_pin),
    .EXT_CLOCK_IN(ext_clk), .COUNT_WRITE(cwr), .COUNT_WRITE_DATA(cwd), .OVERFLOW_FLAG_CLEAR(ofc),
    .GATE_EVENT_FLAG_CLEAR(gfc), .COUNT_HIGH_BYTE(hi), .COUNT_LOW_BYTE(lo), .OVERFLOW_FLAG(of),
    .GATE_EVENT_FLAG(gf), .GATE_ARM_PENDING(gpend), .GATE_VALUE(gval), .OSC_RUNNING(oscr),
    .WAKE_REQUEST(wake), .IRQ_BRANCH(brn));
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic load(input logic [15:0] v);
    cwd = v;
    cwr = 1'h1;
    cyc(1);
    cwr = 1'h0;
  endtask
  task automatic t_wrap;
    ofc = 1'h1;
    load(16'hFFFE);
    ofc = 1'h0;
    {sel, run, oie, pie, global_irq_enable} = 5'h0F;
    cyc(1);
    `CHK("count_max", 16'hFFFF, cnt)
    cyc(1);
    `CHK("count_wrap", 16'h0000, cnt)
    `CHK("overflow_flag", 1'h1, of)
    `CHK("irq_branch", 1'h1, brn)
    cyc(3);
    `CHK("flag_sticky", 1'h1, of)
    ofc = 1'h1;
    cyc(1);
    ofc = 1'h0;
    `CHK("flag_cleared", 1'h0, of)
    $display("t_wrap done");
  endtask
  task automatic t_sleep;
    {slp, sel, sdis, global_irq_enable, ext_run} = 5'h11;
    c0 = cnt;
    cyc(20);
    `CHK("sleep_sys_hold", c0, cnt)
    sel = 1'h1;
    cyc(20);
    `CHK("sleep_sync_hold", c0, cnt)
    `CHK("osc_in_sleep", 1'h1, oscr)
    osc = 1'h0;
    cyc(1);
    `CHK("osc_off", 1'h0, oscr)
    osc = 1'h1;
    sdis = 1'h1;
    cyc(20);
    `CHK("ext_rate", 1'h1, (cnt - c0) > 16'h0000 && (cnt - c0) < 16'h0004)
    load(16'hFFFF);
    for (int i = 0; i < 40 && of !== 1'h1; i++) cyc(1);
    `CHK("wake", 1'h1, wake)
    `CHK("no_branch", 1'h0, brn)
    global_irq_enable = 1'h1;
    cyc(1);
    `CHK("branch", 1'h1, brn)
    {slp, ext_run} = 2'h0;
    cyc(1);
    `CHK("wake_awake", 1'h0, wake)
    ofc = 1'h1;
    cyc(1);
    ofc = 1'h0;
    $display("t_sleep done");
  endtask
  task automatic t_gate;
    {sel, sdis, run, gen, gpol, gspm} = 6'h0F;
    load(16'h0100);
    garm = 1'h1;
    cyc(1);
    garm = 1'h0;
    cyc(1);
    `CHK("armed", 1'h1, gpend)
    `CHK("hold_gate_off", 16'h0100, cnt)
    gate_lvl = 1'h1;
    cyc(6);
    `CHK("count_in_gate", 1'h1, cnt > 16'h0100)
    `CHK("gate_value", 1'h1, gval)
    gate_lvl = 1'h0;
    for (int i = 0; i < 8 && gpend !== 1'h0; i++) cyc(1);
    `CHK("done", 1'h0, gpend)
    `CHK("gate_event", 1'h1, gf)
    c0 = cnt;
    gate_lvl = 1'h1;
    cyc(4);
    `CHK("hold_after_done", c0, cnt)
    gfc = 1'h1;
    cyc(1);
    gfc = 1'h0;
    `CHK("gate_flag_clear", 1'h0, gf)
    $display("t_gate done");
  endtask
  // toggle mode flips the gate value on every tick while the pin is active, so half the ticks count
  task automatic t_toggle;
    {gspm, gtm, gate_lvl} = 3'h2;
    load(16'h0200);
    gate_lvl = 1'h1;
    cyc(8);
    `CHK("toggle_count", 16'h0203, cnt)
    gate_lvl = 1'h0;
    $display("t_toggle done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // more than ten times the expected run length
  initial begin
    #200000;
    n_fail++;
    final_report();
  end
  initial begin
    {rst, run, sel, sdis, oie, pie, global_irq_enable, slp} = 8'h80;
    {gen, gpol, gtm, gspm, garm, ext_run, gate_lvl} = 7'h00;
    {cwr, ofc, gfc, osc, cwd} = {4'h1, 16'h0000};
    cyc(5);
    rst = 1'h0;
    `CHK("reset_count", 16'h0000, cnt)
    cyc(1);
    t_wrap();
    t_sleep();
    t_gate();
    t_toggle();
    final_report();
  end
endmodule // tb
`default_nettype wire
